// ### rtl/spc_regs.sv
/*
 Supply and push-button control register bank: voltage codes, enables,
 discharge and fault gating for three regulators, keep-alive enable, button
 interrupt enables and the watchdog soft-reset enable with its timer.
 Assumes a serial interface front end that presents one byte per completed
 transfer as a single-cycle strobe, and analog power-good levels from pins.
*/
`timescale 1ns/1ps
`include "spc_defines.svh"

module spc_regs #(
   parameter int unsigned WDT_CYCLES = `SPC_WDT_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   input  wire logic [2:0]  power_good_in,
   input  wire logic [2:0]  fault_in,
   input  wire logic        push_button_input_n,
   input  wire logic        sleep_entry,
   input  wire logic        watchdog_kick,
   output logic [17:0]      output_voltage_code,
   output logic [2:0]       supply_enable,
   output logic [2:0]       discharge_active,
   output logic             keepalive_enable,
   output logic             fault_irq_req,
   output logic             button_press_irq,
   output logic             button_release_irq,
   output logic             soft_reset_start
);

   localparam logic [`SPC_WDT_W-1:0] WDT_LAST = `SPC_WDT_W'(WDT_CYCLES - 1);

   spc_pkg::spc_state_t st_r;
   spc_pkg::spc_state_t st_nxt;

   spc_btn_if btn ();

   // Button pin crossing and edge detection
   spc_btn_sync u_btn (
      .clk                 (clk),
      .rst_n               (rst_n),
      .push_button_input_n (push_button_input_n),
      .btn                 (btn)
   );

   // Byte address to register; unknown offsets decode to none
   function automatic spc_pkg::spc_reg_t spc_decode(input logic [7:0] addr);
      unique case (addr)
         `SPC_OFF_S10_VSEL: spc_decode = spc_pkg::SPC_R_S10_V;
         `SPC_OFF_S10_CTRL: spc_decode = spc_pkg::SPC_R_S10_C;
         `SPC_OFF_S11_VSEL: spc_decode = spc_pkg::SPC_R_S11_V;
         `SPC_OFF_S11_CTRL: spc_decode = spc_pkg::SPC_R_S11_C;
         `SPC_OFF_S12_VSEL: spc_decode = spc_pkg::SPC_R_S12_V;
         `SPC_OFF_S12_CTRL: spc_decode = spc_pkg::SPC_R_S12_C;
         `SPC_OFF_KA_EN:    spc_decode = spc_pkg::SPC_R_KA;
         `SPC_OFF_BUTTON_WATCHDOG_CONTROL:  spc_decode = spc_pkg::SPC_R_PB;
         default:           spc_decode = spc_pkg::SPC_R_NONE;
      endcase
   endfunction

   // Supply number served by a decoded register, 3 when none
   function automatic logic [1:0] spc_sup_sel(input spc_pkg::spc_reg_t r);
      unique case (r)
         spc_pkg::SPC_R_S10_V, spc_pkg::SPC_R_S10_C: spc_sup_sel = 2'h0;
         spc_pkg::SPC_R_S11_V, spc_pkg::SPC_R_S11_C: spc_sup_sel = 2'h1;
         spc_pkg::SPC_R_S12_V, spc_pkg::SPC_R_S12_C: spc_sup_sel = 2'h2;
         default:                                    spc_sup_sel = 2'h3;
      endcase
   endfunction

   // Voltage register or control register of a supply
   function automatic logic spc_is_vsel(input spc_pkg::spc_reg_t r);
      spc_is_vsel = (r == spc_pkg::SPC_R_S10_V) || (r == spc_pkg::SPC_R_S11_V) ||
                    (r == spc_pkg::SPC_R_S12_V);
   endfunction

   // Control byte of one supply as the host sees it
   function automatic logic [7:0] spc_ctrl_byte(input spc_pkg::spc_supply_t s,
                                                 input logic pg);
      logic [7:0] b;
      b = 8'h00;                                                      // R10
      b[`SPC_BIT_EN]  = s.en;
      b[`SPC_BIT_DIS] = s.dis;
      b[`SPC_BIT_FLT] = s.allow;
      b[`SPC_BIT_PG]  = pg;                                           // R5
      spc_ctrl_byte = b;
   endfunction

   spc_pkg::spc_reg_t wr_reg;
   spc_pkg::spc_reg_t rd_reg;
   logic [1:0]        wr_sup;
   logic [1:0]        rd_sup;

   assign wr_reg = spc_decode(reg_addr);
   assign rd_reg = wr_reg;
   assign wr_sup = spc_sup_sel(wr_reg);
   assign rd_sup = spc_sup_sel(rd_reg);

   // Next state of the whole bank
   always_comb begin
      st_nxt = st_r;

      // Power-good crossing; status moves once stages two and three agree
      st_nxt.pg_s1 = power_good_in;
      st_nxt.pg_s2 = st_r.pg_s1;
      st_nxt.pg_s3 = st_r.pg_s2;
      for (int i = 0; i < 3; i++) begin
         if (st_r.pg_s2[i] == st_r.pg_s3[i]) begin
            st_nxt.pg[i] = st_r.pg_s3[i];                             // R5
         end
      end

      // Host writes land only on the completed-transfer strobe
      if (reg_wr) begin                                               // R11
         if (wr_sup != 2'h3) begin
            if (spc_is_vsel(wr_reg)) begin
               st_nxt.sup[wr_sup].code = reg_wdata[`SPC_VSEL_MSB:0];  // R1
            end else begin
               st_nxt.sup[wr_sup].en    = reg_wdata[`SPC_BIT_EN];     // R2
               st_nxt.sup[wr_sup].dis   = reg_wdata[`SPC_BIT_DIS];    // R3
               st_nxt.sup[wr_sup].allow = reg_wdata[`SPC_BIT_FLT];    // R4
            end
         end else if (wr_reg == spc_pkg::SPC_R_KA) begin
            st_nxt.ka_en = reg_wdata[`SPC_BIT_EN];                    // R2
         end else if (wr_reg == spc_pkg::SPC_R_PB) begin
            st_nxt.press_allow   = reg_wdata[`SPC_BIT_PRESS];         // R6
            st_nxt.release_allow = reg_wdata[`SPC_BIT_RELEASE];       // R7
            st_nxt.wdsr_en       = reg_wdata[`SPC_BIT_WDSR];          // R8
         end
      end

      // Sleep entry wins over a host write in the same cycle
      if (sleep_entry) begin
         st_nxt.wdsr_en = 1'b0;                                       // R9
      end

      // Read data captured from state; reserved and unmapped bits read zero
      if (reg_rd) begin
         st_nxt.rdata = 8'h00;                                        // R10
         if (rd_sup != 2'h3) begin
            if (spc_is_vsel(rd_reg)) begin
               st_nxt.rdata[`SPC_VSEL_MSB:0] = st_r.sup[rd_sup].code;
            end else begin
               st_nxt.rdata = spc_ctrl_byte(st_r.sup[rd_sup], st_r.pg[rd_sup]);
            end
         end else if (rd_reg == spc_pkg::SPC_R_KA) begin
            st_nxt.rdata[`SPC_BIT_EN] = st_r.ka_en;
         end else if (rd_reg == spc_pkg::SPC_R_PB) begin
            st_nxt.rdata[`SPC_BIT_PRESS]   = st_r.press_allow;
            st_nxt.rdata[`SPC_BIT_RELEASE] = st_r.release_allow;
            st_nxt.rdata[`SPC_BIT_WDSR]    = st_r.wdsr_en;
         end
      end

      // Watchdog counts only while enabled; a kick restarts the period
      st_nxt.soft_rst = 1'b0;
      if (!st_r.wdsr_en || watchdog_kick) begin
         st_nxt.wdt_cnt = '0;
      end else if (st_r.wdt_cnt == WDT_LAST) begin
         st_nxt.wdt_cnt  = '0;
         st_nxt.soft_rst = 1'b1;                                      // R8
      end else begin
         st_nxt.wdt_cnt = st_r.wdt_cnt + `SPC_WDT_W'(1);
      end

      // Button events gated by their enables
      st_nxt.press_irq   = btn.press & st_r.press_allow;              // R6
      st_nxt.release_irq = btn.lift & st_r.release_allow;             // R7

      // Any allowed regulator fault requests an interrupt
      st_nxt.fault_irq = 1'b0;
      for (int i = 0; i < 3; i++) begin
         st_nxt.fault_irq = st_nxt.fault_irq | (fault_in[i] & st_r.sup[i].allow); // R4
      end
   end

   // Single state register of the bank
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r               <= '0;
         for (int i = 0; i < 3; i++) begin
            st_r.sup[i].code  <= `SPC_VSEL_RST;
            st_r.sup[i].en    <= `SPC_EN_RST;
            st_r.sup[i].dis   <= `SPC_DIS_RST;
            st_r.sup[i].allow <= `SPC_FLT_RST;
         end
         st_r.ka_en         <= `SPC_KA_RST;
         st_r.press_allow   <= `SPC_PB_RST;
         st_r.release_allow <= `SPC_PB_RST;
         st_r.wdsr_en       <= `SPC_WDSR_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   generate
      for (genvar g = 0; g < 3; g++) begin : g_sup
         assign output_voltage_code[6*g +: 6] = st_r.sup[g].code;    // R1
         assign supply_enable[g]              = st_r.sup[g].en;      // R2
         // Discharge only matters while the regulator is off
         assign discharge_active[g] = st_r.sup[g].dis & ~st_r.sup[g].en; // R3
      end
   endgenerate

   assign keepalive_enable   = st_r.ka_en;
   assign fault_irq_req      = st_r.fault_irq;
   assign button_press_irq   = st_r.press_irq;
   assign button_release_irq = st_r.release_irq;
   assign soft_reset_start   = st_r.soft_rst;
   assign reg_rdata          = st_r.rdata;

   // Checks on ports and internal state; reset cycles are left out since fields load then
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_ctrl0_wr;
      reg_wr && (reg_addr == `SPC_OFF_S10_CTRL);
   endsequence

   sequence s_off_with_dis;
      reg_wdata[`SPC_BIT_DIS] && !reg_wdata[`SPC_BIT_EN] && !sleep_entry;
   endsequence

   a_vsel_write: assert property ( // R1
      reg_wr && (reg_addr == `SPC_OFF_S11_VSEL)
      |=> output_voltage_code[11:6] == $past(reg_wdata[5:0]))
      else $error("voltage code not taken from write");

   a_enable_write: assert property ( // R2
      s_ctrl0_wr |=> supply_enable[0] == $past(reg_wdata[7]))
      else $error("enable bit not taken from write");

   a_discharge_off: assert property ( // R3
      (s_ctrl0_wr and s_off_with_dis)
      |=> discharge_active[0] ##1 (discharge_active[0] || $past(reg_wr)))
      else $error("discharge not active while shut down");

   a_fault_gate: assert property ( // R4
      fault_irq_req |-> $past(|(fault_in & {st_r.sup[2].allow, st_r.sup[1].allow,
                                             st_r.sup[0].allow})))
      else $error("fault interrupt raised while masked");

   a_pg_readback: assert property ( // R5
      reg_rd && (reg_addr == `SPC_OFF_S12_CTRL) |=> reg_rdata[0] == $past(st_r.pg[2]))
      else $error("power-good status not reported");

   a_press_irq: assert property ( // R6
      btn.press && st_r.press_allow |=> button_press_irq)
      else $error("press interrupt missed");

   a_release_irq: assert property ( // R7
      button_release_irq |-> $past(btn.lift) && $past(st_r.release_allow))
      else $error("release interrupt without enabled release");

   a_wdt_expire: assert property ( // R8
      soft_reset_start |-> $past(st_r.wdsr_en) && $past(st_r.wdt_cnt) == WDT_LAST)
      else $error("soft reset without watchdog expiry");

   a_sleep_clear: assert property ( // R9
      sleep_entry |=> !st_r.wdsr_en ##1 !soft_reset_start)
      else $error("watchdog enable survived sleep entry");

   a_reserved_zero: assert property ( // R10
      reg_rd && (reg_addr == `SPC_OFF_KA_EN) |=> reg_rdata[6:0] == 7'h00)
      else $error("reserved bits read nonzero");

   a_write_only: assert property ( // R11
      !reg_wr |=> $stable(output_voltage_code) && $stable(supply_enable))
      else $error("field changed without a write");

   a_ka_write: assert property ( // R2
      reg_wr && (reg_addr == `SPC_OFF_KA_EN)
      |=> keepalive_enable == $past(reg_wdata[`SPC_BIT_EN]))
      else $error("keep-alive enable not taken from write");

   a_wdsr_write: assert property ( // R8
      reg_wr && (reg_addr == `SPC_OFF_BUTTON_WATCHDOG_CONTROL) && !sleep_entry
      |=> st_r.wdsr_en == $past(reg_wdata[`SPC_BIT_WDSR]))
      else $error("watchdog enable not taken from write");

   a_wdt_idle: assert property ( // R8
      !st_r.wdsr_en |=> st_r.wdt_cnt == '0)
      else $error("watchdog counting while disabled");

   a_fault_level: assert property ( // R4
      !(|fault_in) |=> !fault_irq_req)
      else $error("fault interrupt held without a fault");

   a_unmapped_read: assert property ( // R10
      reg_rd && (rd_reg == spc_pkg::SPC_R_NONE) |=> reg_rdata == 8'h00)
      else $error("unmapped offset read nonzero");

   a_rdata_hold: assert property ( // R11
      !reg_rd |=> $stable(reg_rdata))
      else $error("read byte changed without a read");

endmodule

// ### rtl/spc_defines.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 supply and push-button control register bank.
 Assumes inclusion by the package and by every design file that decodes fields.
*/
// Operation
// R1 - Six-bit voltage code per regulator, read/write
// R2 - Control bit 7 enables regulator
// R3 - Bit 2 discharges output while shut down
// R4 - Bit 1 set lets faults interrupt
// R5 - Bit 0 reads live power-good status
// R6 - Press interrupt when button bit 7 set
// R7 - Release interrupt when button bit 6 set
// R8 - Watchdog runs; expiry starts soft reset
// R9 - Sleep entry clears watchdog soft-reset enable
// R10 - Reserved bits read zero, writes ignored
// R11 - Byte access; fields change on completed write
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// Byte offsets of the bank
`define SPC_OFF_S10_VSEL  8'h80
`define SPC_OFF_S10_CTRL  8'h81
`define SPC_OFF_S11_VSEL  8'h90
`define SPC_OFF_S11_CTRL  8'h91
`define SPC_OFF_S12_VSEL  8'hA0
`define SPC_OFF_S12_CTRL  8'hA1
`define SPC_OFF_KA_EN     8'hB1
`define SPC_OFF_BUTTON_WATCHDOG_CONTROL   8'hC0

// Field positions
`define SPC_VSEL_MSB      5
`define SPC_BIT_EN        7
`define SPC_BIT_DIS       2
`define SPC_BIT_FLT       1
`define SPC_BIT_PG        0
`define SPC_BIT_PRESS     7
`define SPC_BIT_RELEASE   6
`define SPC_BIT_WDSR      1

// Reset values
`define SPC_VSEL_RST      6'h00
`define SPC_EN_RST        1'b0
`define SPC_DIS_RST       1'b0
`define SPC_FLT_RST       1'b0
`define SPC_KA_RST        1'b1
`define SPC_PB_RST        1'b0
`define SPC_WDSR_RST      1'b0

// Watchdog timing
`define SPC_WDT_W         24
`define SPC_WDT_CYCLES    1024

`endif

// ### rtl/spc_pkg.sv
/*
 Types shared by the supply control register bank and its button front end.
 Assumes the defines header is on the include path.
*/
`include "spc_defines.svh"

package spc_pkg;

   // Decoded register of the bank
   typedef enum logic [3:0] {
      SPC_R_NONE  = 4'h0,
      SPC_R_S10_V = 4'h1,
      SPC_R_S10_C = 4'h2,
      SPC_R_S11_V = 4'h3,
      SPC_R_S11_C = 4'h4,
      SPC_R_S12_V = 4'h5,
      SPC_R_S12_C = 4'h6,
      SPC_R_KA    = 4'h7,
      SPC_R_PB    = 4'h8
   } spc_reg_t;

   // One regulator's writable fields
   typedef struct packed {
      logic [`SPC_VSEL_MSB:0] code;
      logic                   en;
      logic                   dis;
      logic                   allow;
   } spc_supply_t;

   // Whole state of the register bank
   typedef struct packed {
      spc_supply_t [2:0]      sup;
      logic                   ka_en;
      logic                   press_allow;
      logic                   release_allow;
      logic                   wdsr_en;
      logic [2:0]             pg_s1;
      logic [2:0]             pg_s2;
      logic [2:0]             pg_s3;
      logic [2:0]             pg;
      logic [7:0]             rdata;
      logic [`SPC_WDT_W-1:0]  wdt_cnt;
      logic                   soft_rst;
      logic                   press_irq;
      logic                   release_irq;
      logic                   fault_irq;
   } spc_state_t;

   // State of the push-button front end
   typedef struct packed {
      logic [2:0]             sync;
      logic                   level;
      logic                   press;
      logic                   lift;
   } spc_btn_t;

endpackage

// ### rtl/spc_btn_if.sv
/*
 Carrier for push-button edge events between front end and register bank.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface spc_btn_if;
   logic press;
   logic lift;
   modport src (output press, output lift);
   modport dst (input press, input lift);
endinterface

// ### rtl/spc_btn_sync.sv
/*
 Push-button front end: three-stage synchroniser and edge detector.
 Assumes the pin is asynchronous and active low; bounce filtering lies outside.
*/
`timescale 1ns/1ps

module spc_btn_sync (
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  push_button_input_n,
   spc_btn_if.src     btn
);

   spc_pkg::spc_btn_t st_r;
   spc_pkg::spc_btn_t st_nxt;

   // Level follows the pin once stages two and three agree
   always_comb begin
      st_nxt         = st_r;
      st_nxt.sync    = {st_r.sync[1:0], push_button_input_n};
      if (st_r.sync[1] == st_r.sync[2]) begin
         st_nxt.level = ~st_r.sync[2];
      end
      st_nxt.press   = ~st_r.level & st_nxt.level;
      st_nxt.lift    = st_r.level & ~st_nxt.level;
   end

   // Pin idles high, so the chain starts released
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= '{sync: 3'h7, level: 1'b0, press: 1'b0, lift: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign btn.press   = st_r.press;
   assign btn.lift    = st_r.lift;

   // Edges come one at a time
   a_edge_excl: assert property (@(posedge clk) disable iff (!rst_n)
      !(st_r.press && st_r.lift))
      else $error("press and release pulses overlap");

   // A press needs stages two and three to agree on a low pin
   a_press_agree: assert property (@(posedge clk) disable iff (!rst_n) // R6
      st_r.press |-> $past(st_r.sync[2:1] == 2'h0))
      else $error("press pulse without settled pin");

endmodule

// ### verif/spc_host_model.sv
/*
 Host side model: single-byte register writes and reads into the bank.
 Assumes the bank takes a request on a rising edge and answers a cycle later.
*/
`timescale 1ns/1ps

module spc_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   // Quiet bus before the first transfer
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // Whole byte per transfer; lines inverted after so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // Read byte is taken a cycle and a half after the request edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge clk);
      d = reg_rdata;
   endtask
endmodule

// ### verif/tb_top.sv
/*
 Self-checking bench for the supply and push-button register bank.
 Assumes the host model as register master and a shortened watchdog period.
*/
`timescale 1ns/1ps

module tb_top;
   localparam int unsigned WDT = 16;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } spc_tb_row_t;
   // Write value and expected read-back; power-good held low here
   localparam spc_tb_row_t ROWS [11] = '{
      '{8'h80, 8'hFF, 8'h3F}, '{8'h90, 8'hC1, 8'h01}, '{8'hA0, 8'h2A, 8'h2A},
      '{8'h81, 8'hFF, 8'h86}, '{8'h91, 8'h86, 8'h86}, '{8'hA1, 8'h7F, 8'h06},
      '{8'hB1, 8'h00, 8'h00}, '{8'hB1, 8'hFF, 8'h80}, '{8'hC0, 8'hFF, 8'hC2},
      '{8'hC0, 8'h00, 8'h00}, '{8'hF0, 8'hFF, 8'h00}};

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic [2:0]  pg_in = 3'h0;
   logic [2:0]  flt_in = 3'h0;
   logic        btn_n = 1'b1;
   logic        sleep = 1'b0;
   logic        kick = 1'b0;
   logic [17:0] vcode;
   logic [2:0]  sup_en;
   logic [2:0]  dis_act;
   logic        ka_en;
   logic        flt_irq;
   logic        prs_irq;
   logic        rel_irq;
   logic        srst;
   logic [7:0]  rb;
   int          bad_count = 0;
   int          checks = 0;
   int          n_prs = 0;
   int          n_rel = 0;
   int          n_srst = 0;

   // 250 MHz clock
   always #2 clk = ~clk;

   spc_host_model host (
      .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
   );

   spc_regs #(.WDT_CYCLES(WDT)) dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .power_good_in(pg_in), .fault_in(flt_in), .push_button_input_n(btn_n),
      .sleep_entry(sleep), .watchdog_kick(kick), .output_voltage_code(vcode),
      .supply_enable(sup_en), .discharge_active(dis_act), .keepalive_enable(ka_en),
      .fault_irq_req(flt_irq), .button_press_irq(prs_irq),
      .button_release_irq(rel_irq), .soft_reset_start(srst)
   );

   // Pulse counters at the falling edge, clear of the edge that launches them
   always @(negedge clk) begin
      if (prs_irq === 1'b1) n_prs++;
      if (rel_irq === 1'b1) n_rel++;
      if (srst === 1'b1) n_srst++;
   end

   task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rb);
      chk("read byte", {10'h000, rb}, {10'h000, e});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Hang guard well beyond the planned run
   initial begin
      #40000;
      bad_count++;
      test_done();
   end

   // Main sequence
   initial begin
      cyc(3);
      rst_n = 1'b1;
      foreach (ROWS[i]) begin
         host.wr(ROWS[i].a, ROWS[i].d);
         rdchk(ROWS[i].a, ROWS[i].e);
      end
      chk("voltage codes", vcode, {6'h2A, 6'h01, 6'h3F});
      chk("enables", {15'h0, sup_en}, 18'h00003);
      chk("discharge", {15'h0, dis_act}, 18'h00004);
      chk("keep-alive", {17'h0, ka_en}, 18'h00001);
      // Second reset in mid-run
      rst_n = 1'b0;
      cyc(3);
      rst_n = 1'b1;
      chk("enables reset", {14'h0, ka_en, sup_en}, 18'h00008);
      rdchk(8'hB1, 8'h80);
      rdchk(8'hC0, 8'h00);
      // Power-good status is live and cannot be written
      pg_in = 3'b101;
      cyc(8);
      host.wr(8'h81, 8'h04);
      rdchk(8'h81, 8'h05);
      chk("discharge off", {15'h0, dis_act}, 18'h00001);
      rdchk(8'h91, 8'h00);
      rdchk(8'hA1, 8'h01);
      // Fault gating: only supply10 allowed
      host.wr(8'h81, 8'h02);
      flt_in = 3'b010;
      cyc(3);
      chk("fault masked", {17'h0, flt_irq}, 18'h0);
      flt_in = 3'b001;
      cyc(3);
      chk("fault allowed", {17'h0, flt_irq}, 18'h1);
      flt_in = 3'b000;
      // Press interrupt only, then release interrupt only
      host.wr(8'hC0, 8'h80);
      for (int k = 0; k < 2; k++) begin
         n_prs = 0;
         n_rel = 0;
         btn_n = 1'b0;
         cyc(12);
         btn_n = 1'b1;
         cyc(12);
         chk("press irqs", 18'(n_prs), 18'(1 - k));
         chk("release irqs", 18'(n_rel), 18'(k));
         host.wr(8'hC0, 8'h40);
      end
      // Watchdog expiry, then kicks hold it off
      host.wr(8'hC0, 8'h02);
      n_srst = 0;
      cyc(WDT + 4);
      chk("expiries", 18'(n_srst), 18'h00001);
      n_srst = 0;
      repeat (5) begin
         cyc(8);
         kick = 1'b1;
         cyc(1);
         kick = 1'b0;
      end
      chk("kicked expiries", 18'(n_srst), 18'h00000);
      // Sleep entry drops the enable and stops the watchdog
      sleep = 1'b1;
      cyc(1);
      sleep = 1'b0;
      n_srst = 0;
      rdchk(8'hC0, 8'h00);
      cyc(3 * WDT);
      chk("sleep expiries", 18'(n_srst), 18'h00000);
      test_done();
   end
endmodule
